// ### logic/wir_pkg.sv
package wir_pkg;
	// Source numbering of the upper group
	localparam int          WIR_NUM_SRC      = 50;
	localparam int          WIR_SRC_TB7      = 40;
	localparam int          WIR_SRC_TB8      = 41;
	localparam int          WIR_SRC_TB9      = 42;
	localparam int          WIR_SRC_CAP20    = 43;
	localparam int          WIR_SRC_CAP21    = 44;
	localparam int          WIR_SRC_CAP30    = 45;
	localparam int          WIR_SRC_CAP31    = 46;
	localparam int          WIR_SRC_CAP40    = 47;
	localparam int          WIR_SRC_CAP41    = 48;
	localparam int          WIR_SRC_ADC      = 49;
	localparam int          WIR_NUM_WAKE     = 8;
	localparam int          WIR_PRIO_W       = 3;
	// Register byte offsets
	localparam logic [7:0]  WIR_OFS_MODE     = 8'h00;
	localparam logic [7:0]  WIR_OFS_CLEAR    = 8'h04;
	localparam logic [7:0]  WIR_OFS_MASK     = 8'h08;
	localparam logic [7:0]  WIR_OFS_PRIO_LO  = 8'h0c;
	localparam logic [7:0]  WIR_OFS_PRIO_HI  = 8'h10;
	localparam logic [7:0]  WIR_OFS_STATUS   = 8'h14;
	localparam logic [7:0]  WIR_OFS_IRQ_STS  = 8'h18;
	localparam logic [7:0]  WIR_OFS_IRQ_MSK  = 8'h1c;
	localparam logic [7:0]  WIR_OFS_PRIV     = 8'h20;
	// Mode control layout: 4 bits per wake source, [0]=enable, [3:1]=level
	localparam int          WIR_MODE_STRIDE  = 4;
	localparam int          WIR_MODE_EN_BIT  = 0;
	localparam int          WIR_MODE_LVL_LSB = 1;
	// Status layout
	localparam int          WIR_ST_VALID_BIT = 6;
	localparam int          WIR_ST_ID_LSB    = 0;
	// Reset values
	localparam logic [31:0] WIR_RST_MODE     = 32'h0000_0000;
	localparam logic [31:0] WIR_RST_PRIO     = 32'h0000_0000;
	localparam logic        WIR_RST_GMASK    = 1'h0;
	// AXI responses
	localparam logic [1:0]  WIR_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  WIR_RESP_SLVERR  = 2'h2;
	// Active level encodings
	typedef enum logic [2:0] {
		WIR_LVL_LOW  = 3'b000,
		WIR_LVL_HIGH = 3'b001,
		WIR_LVL_FALL = 3'b010,
		WIR_LVL_RISE = 3'b011
	} wir_level_t;
endpackage

// ### logic/wir_top.sv
`timescale 1ns/1ns
module wir_top
	import wir_pkg::*;
(
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	// Request inputs from pins and peripherals, index is source number
	input  wire logic [WIR_NUM_SRC-1:0]   src_irq,
	// Core side
	input  wire logic                     fault_in,
	output logic                          core_irq,
	output logic [5:0]                    core_irq_id,
	output logic                          hard_fault,
	output logic                          fault_out,
	output logic                          ctx_save,
	output logic                          irq_out,
	// AXI4-Lite slave
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);

	// Wake-capable sources mapped onto the eight detector slots
	localparam int WAKE_SRC [WIR_NUM_WAKE] = '{0, 1, 2, 3, 12, 13, 14, 25};

	// Merge byte lanes of a write into an old word
	function automatic logic [31:0] wir_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

	logic [WIR_NUM_SRC-1:0]  sync1;
	logic [WIR_NUM_SRC-1:0]  sync2;
	logic [WIR_NUM_SRC-1:0]  prev;
	logic [WIR_NUM_WAKE-1:0] wake_req;
	logic [WIR_NUM_SRC-1:0]  route;
	logic [31:0]             wake_mode_ctl;
	logic [WIR_NUM_SRC-1:0]  src_mask;
	logic [31:0]             prio_lo;
	logic [31:0]             prio_hi;
	logic                    global_irq_mask;
	logic [1:0]              evt_sts;
	logic [1:0]              evt_msk;
	logic [7:0]              aw_addr;
	logic                    aw_held;
	logic                    aw_priv;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic                    w_held;
	logic                    wr_go;
	logic                    clr_pulse;
	logic [5:0]              clr_code;
	logic [5:0]              best_id;
	logic                    best_ok;
	logic                    prev_core;

	// Two-flop synchronisers; pins are asynchronous to sys_clk
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			sync1 <= '0;
			sync2 <= '0;
			prev  <= '0;
		end
		else
		begin
			sync1 <= src_irq;
			sync2 <= sync1;
			prev  <= sync2;
		end

	// Wake detectors; edge requests latch, level requests follow input
	generate
		for (genvar g = 0; g < WIR_NUM_WAKE; g++)
		begin : g_wake
			wir_level_t lvl;
			logic       en;
			logic       in_s;
			logic       in_p;
			logic       hit;
			assign lvl  = wir_level_t'(wake_mode_ctl[g*WIR_MODE_STRIDE+WIR_MODE_LVL_LSB +: 3]);
			assign en   = wake_mode_ctl[g*WIR_MODE_STRIDE+WIR_MODE_EN_BIT];
			assign in_s = sync2[WAKE_SRC[g]];
			assign in_p = prev[WAKE_SRC[g]];
			always_comb
				unique case (lvl)
					WIR_LVL_LOW:  hit = !in_s;
					WIR_LVL_HIGH: hit = in_s;
					WIR_LVL_FALL: hit = in_p && !in_s;
					WIR_LVL_RISE: hit = !in_p && in_s;
					default:      hit = 1'b0; // Unused codes detect nothing
				endcase
			always_ff @(posedge sys_clk or negedge nrst)
				if (!nrst)
					wake_req[g] <= 1'b0;
				else if (en && hit)
					wake_req[g] <= 1'b1; // Set wins over a same-cycle clear
				else if (clr_pulse && clr_code == 6'(WAKE_SRC[g]))
					wake_req[g] <= 1'b0; // Edge request held high until cleared
				else if (lvl == WIR_LVL_LOW || lvl == WIR_LVL_HIGH)
					wake_req[g] <= 1'b0; // Level request ceases once inactive
		end
	endgenerate

	// Route: wake sources only via detectors, others direct, high active
	always_comb
	begin
		route = sync2;
		for (int k = 0; k < WIR_NUM_WAKE; k++)
			route[WAKE_SRC[k]] = wake_req[k];
		route = route & ~src_mask;
	end

	// Priority selection; strict less-than keeps the lowest number on ties
	always_comb
	begin
		logic [WIR_PRIO_W-1:0] best_p;
		logic [WIR_PRIO_W-1:0] p;
		best_p  = '1;
		best_id = '0;
		best_ok = 1'b0;
		p       = '0;
		for (int s = 0; s < WIR_NUM_SRC; s++)
		begin
			p = (s < 10) ? prio_lo[s*WIR_PRIO_W +: WIR_PRIO_W] : 3'(prio_hi >> ((s % 10) * WIR_PRIO_W));
			if (s >= 20)
				p = 3'h0; // Only 20 sources carry programmable priority here
			if (route[s] && (!best_ok || p < best_p))
			begin
				best_ok = 1'b1;
				best_p  = p;
				best_id = 6'(s);
			end
		end
	end

	// Core request output and fault escalation
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			core_irq    <= 1'b0;
			core_irq_id <= '0;
			hard_fault  <= 1'b0;
			fault_out   <= 1'b0;
			ctx_save    <= 1'b0;
			prev_core   <= 1'b0;
		end
		else
		begin
			core_irq    <= best_ok && !global_irq_mask;
			core_irq_id <= best_id;
			hard_fault  <= fault_in && global_irq_mask;
			fault_out   <= fault_in && !global_irq_mask;
			prev_core   <= core_irq;
			ctx_save    <= core_irq && !prev_core; // Context push on accept
		end

	assign wr_go = aw_held && w_held && !s_axi_bvalid;

	// Write channel capture, address and data in either order
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			aw_priv <= 1'b0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				aw_priv <= s_axi_awprot[0];
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end

	// Ready flags registered, low while a beat is held
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end

	// Register writes and write response
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			wake_mode_ctl   <= WIR_RST_MODE;
			src_mask        <= '0;
			prio_lo         <= WIR_RST_PRIO;
			prio_hi         <= WIR_RST_PRIO;
			global_irq_mask <= WIR_RST_GMASK;
			evt_msk         <= '0;
			clr_pulse       <= 1'b0;
			clr_code        <= '0;
			s_axi_bvalid    <= 1'b0;
			s_axi_bresp     <= WIR_RESP_OKAY;
		end
		else
		begin
			clr_pulse <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= WIR_RESP_OKAY;
				unique case (aw_addr)
					WIR_OFS_MODE:    wake_mode_ctl <= wir_merge(wake_mode_ctl, w_data, w_strb);
					WIR_OFS_CLEAR:
					begin
						clr_pulse <= 1'b1;
						clr_code  <= w_data[5:0];
					end
					WIR_OFS_MASK:    src_mask[31:0] <= w_data; // Lower 32 sources only; upper ones always pass
					WIR_OFS_PRIO_LO: prio_lo <= wir_merge(prio_lo, w_data, w_strb);
					WIR_OFS_PRIO_HI: prio_hi <= wir_merge(prio_hi, w_data, w_strb);
					WIR_OFS_IRQ_MSK: evt_msk <= w_data[1:0];
					WIR_OFS_PRIV:
						if (aw_priv)
							global_irq_mask <= w_data[0]; // Unprivileged writes ignored
					WIR_OFS_STATUS, WIR_OFS_IRQ_STS: ;
					default:         s_axi_bresp <= WIR_RESP_SLVERR;
				endcase
			end
		end

	// Sticky events: escalated fault and core request; write one clears, set wins
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			evt_sts <= '0;
			irq_out <= 1'b0;
		end
		else
		begin
			for (int e = 0; e < 2; e++)
				if ((e == 0) ? hard_fault : ctx_save)
					evt_sts[e] <= 1'b1;
				else if (wr_go && aw_addr == WIR_OFS_IRQ_STS && w_strb[0] && w_data[e])
					evt_sts[e] <= 1'b0;
			irq_out <= |(evt_sts & evt_msk);
		end

	// Read channel, one cycle after address
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= WIR_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= WIR_RESP_OKAY;
				unique case (s_axi_araddr)
					WIR_OFS_MODE:    s_axi_rdata <= wake_mode_ctl;
					WIR_OFS_CLEAR:   s_axi_rdata <= '0;
					WIR_OFS_MASK:    s_axi_rdata <= src_mask[31:0];
					WIR_OFS_PRIO_LO: s_axi_rdata <= prio_lo;
					WIR_OFS_PRIO_HI: s_axi_rdata <= prio_hi;
					WIR_OFS_STATUS:  s_axi_rdata <= 32'({wake_req, 1'b0, best_ok, best_id}) << WIR_ST_ID_LSB;
					WIR_OFS_IRQ_STS: s_axi_rdata <= {30'h0, evt_sts};
					WIR_OFS_IRQ_MSK: s_axi_rdata <= {30'h0, evt_msk};
					WIR_OFS_PRIV:    s_axi_rdata <= {31'h0, global_irq_mask};
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= WIR_RESP_SLVERR;
					end
				endcase
			end
		end

endmodule // wir_top

// ### verif/wir_props.sv
`timescale 1ns/1ns
module wir_props (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Core side
	input wire logic        fault_in,
	input wire logic        core_irq,
	input wire logic        ctx_save,
	input wire logic        hard_fault,
	input wire logic        fault_out,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Both write beats taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Request line goes from idle to asserted
	sequence s_irq_rise;
		!core_irq ##1 core_irq;
	endsequence
	a_ctx_on_rise: assert property (s_irq_rise |-> ##[0:1] ctx_save) else $error("no context save");
	a_ctx_pulse: assert property (ctx_save |=> !ctx_save) else $error("context save too long");
	a_fault_route: assert property (1 |=> (hard_fault | fault_out) == $past(fault_in)) else $error("fault lost");
	a_fault_excl: assert property (!(hard_fault && fault_out)) else $error("fault on both paths");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("no read data");
	a_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid) else $error("no write response");
endmodule // wir_props
bind wir_top wir_props u_props (.*);

// ### verif/wir_core_model.sv
`timescale 1ns/1ns
module wir_core_model
	import wir_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       nrst,
	// Request from the routing block
	input wire logic       core_irq,
	input wire logic [5:0] core_irq_id,
	input wire logic       ctx_save,
	// Service record
	output logic [5:0]     svc_id,
	output logic [7:0]     svc_n
);
	// A high level is a request; the winner is taken when context is pushed
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			svc_id <= 6'h00;
			svc_n  <= 8'h00;
		end
		else if (ctx_save && core_irq)
		begin
			svc_id <= core_irq_id;
			svc_n  <= svc_n + 8'h01;
		end
	end
endmodule // wir_core_model

// ### verif/wir_top_test.sv
`timescale 1ns/1ns
module wir_top_test
	import wir_pkg::*;
;
	logic                   sys_clk, nrst, fault_in, core_irq, hard_fault, fault_out, ctx_save, irq_out;
	logic [WIR_NUM_SRC-1:0] src_irq;
	logic [5:0]             core_irq_id, svc_id;
	logic [7:0]             s_axi_awaddr, s_axi_araddr;
	logic [2:0]             s_axi_awprot;
	logic [3:0]             s_axi_wstrb;
	logic [31:0]            s_axi_wdata, s_axi_rdata, data;
	logic [1:0]             s_axi_bresp, s_axi_rresp, resp;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic                   s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int                     bad_count, checked;
	wir_top dut (.sys_clk, .nrst, .src_irq, .fault_in, .core_irq, .core_irq_id, .hard_fault, .fault_out,
		.ctx_save, .irq_out, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	wir_core_model core (.sys_clk, .nrst, .core_irq, .core_irq_id, .ctx_save, .svc_id, .svc_n());
	// Free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Both write beats offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p = 3'h0);
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_awprot  <= p;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!s_axi_bvalid)
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!s_axi_rvalid)
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task final_report;
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the sequence needs
	initial
	begin
		#400000;
		bad_count++;
		final_report();
	end
	// Main sequence
	initial
	begin
		{nrst, fault_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		src_irq = '0;
		tick(2);
		nrst <= 1'b1;
		tick(2);
		rd(WIR_OFS_MODE);
		chk(data, WIR_RST_MODE);
		rd(WIR_OFS_PRIO_LO);
		chk(data, WIR_RST_PRIO);
		rd(8'h40);
		chk(resp, WIR_RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(resp, WIR_RESP_SLVERR);
		// Every upper source reaches the core under its own number
		for (int i = WIR_SRC_TB7; i <= WIR_SRC_ADC; i++)
		begin
			src_irq[i] <= 1'b1;
			tick(6);
			chk(core_irq_id, i);
			src_irq[i] <= 1'b0;
			tick(6);
			chk(core_irq, 1'b0);
		end
		// Simultaneous equal priority: lower number first
		src_irq[WIR_SRC_CAP30] <= 1'b1;
		src_irq[WIR_SRC_TB8] <= 1'b1;
		tick(6);
		chk(svc_id, WIR_SRC_TB8);
		src_irq[WIR_SRC_TB8] <= 1'b0;
		tick(6);
		chk(core_irq_id, WIR_SRC_CAP30);
		src_irq[WIR_SRC_CAP30] <= 1'b0;
		// Programmed priority beats number: source 6 at level 7
		wr(WIR_OFS_PRIO_LO, 32'h001c_0000);
		src_irq[6] <= 1'b1;
		src_irq[9] <= 1'b1;
		tick(6);
		chk(core_irq_id, 32'd9);
		wr(WIR_OFS_PRIO_LO, 32'h0);
		tick(6);
		chk(core_irq_id, 32'd6);
		src_irq[6] <= 1'b0;
		src_irq[9] <= 1'b0;
		// Source mask blocks a direct line until lifted
		wr(WIR_OFS_MASK, 32'h0000_0040);
		src_irq[6] <= 1'b1;
		tick(6);
		chk(core_irq, 1'b0);
		wr(WIR_OFS_MASK, 32'h0);
		tick(6);
		chk(core_irq, 1'b1);
		chk(core_irq_id, 32'd6);
		src_irq[6] <= 1'b0;
		// Mask at core, level first, clear, enable, unmask: source 13 rising, source 0 high level
		wr(WIR_OFS_PRIV, 32'h1, 3'h1);
		wr(WIR_OFS_MODE, 32'h0060_0002);
		wr(WIR_OFS_CLEAR, 32'd13);
		wr(WIR_OFS_MODE, 32'h0070_0003);
		wr(WIR_OFS_PRIV, 32'h0, 3'h1);
		src_irq[13] <= 1'b1;
		tick(7);
		chk(core_irq, 1'b1);
		src_irq[13] <= 1'b0;
		tick(7);
		chk(core_irq_id, 32'd13);
		rd(WIR_OFS_STATUS);
		chk(data, 32'h0000_2000 | (32'h1 << WIR_ST_VALID_BIT) | 32'd13);
		wr(WIR_OFS_CLEAR, 32'd13);
		tick(2);
		chk(core_irq, 1'b0);
		src_irq[13] <= 1'b1;
		tick(7);
		chk(core_irq, 1'b1);
		wr(WIR_OFS_CLEAR, 32'd13);
		src_irq[13] <= 1'b0;
		src_irq[0] <= 1'b1;
		tick(7);
		chk(core_irq_id, 32'd0);
		src_irq[0] <= 1'b0;
		tick(7);
		chk(core_irq, 1'b0);
		// Global mask: unprivileged write ignored, privileged write blocks
		wr(WIR_OFS_PRIV, 32'h1);
		src_irq[WIR_SRC_TB9] <= 1'b1;
		tick(6);
		chk(core_irq, 1'b1);
		wr(WIR_OFS_PRIV, 32'h1, 3'h1);
		tick(3);
		chk(core_irq, 1'b0);
		fault_in <= 1'b1;
		tick(2);
		chk(hard_fault, 1'b1);
		chk(fault_out, 1'b0);
		fault_in <= 1'b0;
		wr(WIR_OFS_PRIV, 32'h0, 3'h1);
		tick(3);
		chk(core_irq, 1'b1);
		src_irq[WIR_SRC_TB9] <= 1'b0;
		// Event interrupt: mask, raise, clear by writing ones
		wr(WIR_OFS_IRQ_MSK, 32'h1);
		tick(2);
		chk(irq_out, 1'b1);
		wr(WIR_OFS_IRQ_MSK, 32'h0);
		tick(2);
		chk(irq_out, 1'b0);
		wr(WIR_OFS_IRQ_STS, 32'h3);
		rd(WIR_OFS_IRQ_STS);
		chk(data, 32'h0);
		wr(WIR_OFS_IRQ_MSK, 32'h3);
		tick(2);
		chk(irq_out, 1'b0);
		// Low level on source 1 and falling edge on source 25, set up under the core mask
		wr(WIR_OFS_PRIV, 32'h1, 3'h1);
		wr(WIR_OFS_MODE, 32'h4000_0000);
		wr(WIR_OFS_CLEAR, 32'd25);
		wr(WIR_OFS_MODE, 32'h5000_0010);
		tick(3);
		chk(core_irq, 1'b0);
		wr(WIR_OFS_PRIV, 32'h0, 3'h1);
		tick(3);
		chk(core_irq, 1'b1);
		chk(core_irq_id, 32'd1);
		src_irq[1] <= 1'b1;
		src_irq[25] <= 1'b1;
		tick(6);
		chk(core_irq, 1'b0);
		src_irq[25] <= 1'b0;
		tick(6);
		chk(core_irq, 1'b1);
		chk(core_irq_id, 32'd25);
		wr(WIR_OFS_CLEAR, 32'd25);
		tick(2);
		chk(core_irq, 1'b0);
		final_report();
	end
endmodule // wir_top_test
